// file: verilog/lsd_pkg.sv
package lsd_pkg;

  // Operation classes produced by the decoder
  typedef enum logic [3:0] {
    LSD_OP_NONE, LSD_OP_INVERT, LSD_OP_XOR_RM, LSD_OP_XOR_ACC, LSD_OP_TEST_RM,
    LSD_OP_TEST_IMM, LSD_OP_TEST_ACC, string_load_op, string_port_output_op, string_move_op
  } lsd_op_t;

  // Decoder states
  typedef enum logic [1:0] {LSD_IDLE, LSD_MODRM, LSD_IMM, LSD_EXEC} lsd_st_t;

  // One decoded instruction
  typedef struct packed {
    lsd_op_t op;
    logic word;
    logic mem;
    logic rep;
    logic [7:0] cost;
  } lsd_dec_t;

  // Opcode values and masks (low bit is the width bit)
  localparam logic [7:0] LSD_PREFIX_REP = 8'h00_F2;
  localparam logic [7:0] LSD_MASK_W = 8'h00_FE;
  localparam logic [7:0] LSD_MASK_DW = 8'h00_FC;
  localparam logic [7:0] LSD_OPC_GRP3 = 8'h00_F6;
  localparam logic [7:0] LSD_OPC_XOR_RM = 8'h00_30;
  localparam logic [7:0] LSD_OPC_XOR_ACC = 8'h00_34;
  localparam logic [7:0] LSD_OPC_TEST_RM = 8'h00_84;
  localparam logic [7:0] LSD_OPC_TEST_ACC = 8'h00_A8;
  localparam logic [7:0] LSD_OPC_LOAD = 8'h00_AC;
  localparam logic [7:0] LSD_OPC_OUT = 8'h00_6E;
  localparam logic [7:0] LSD_OPC_MOVE = 8'h00_A4;
  localparam logic [2:0] LSD_REG_INVERT = 3'h2;
  localparam logic [2:0] LSD_REG_TEST = 3'h0;
  localparam logic [1:0] LSD_MOD_REG = 2'h3;

  // Execution costs in core clocks
  localparam logic [7:0] LSD_CYC_REG = 8'h00_01;
  localparam logic [7:0] LSD_CYC_MEM = 8'h00_07;
  localparam logic [7:0] LSD_CYC_MEM_IMM = 8'h00_08;
  localparam logic [7:0] LSD_CYC_STRING = 8'h00_0D;
  localparam logic [7:0] LSD_CYC_REP_MOVE = 8'h00_04;
  localparam logic [7:0] LSD_CYC_REP_OUT = 8'h00_05;
  localparam logic [7:0] LSD_CYC_REP_LOAD = 8'h00_03;
  localparam logic [7:0] LSD_CYC_ITER = 8'h00_09;

endpackage

// file: verilog/lsd_decoder.sv
`timescale 1ns/100ps
// How it works
// - Group-3 reg 010 inverts; cost 1/7
// - Xor forms: rm 1/7, accumulator immediate 1
// - Test rm with reg: flags only, 1/7
// - Test immediate: group-3 reg 000 1/8, accumulator 1
// - Single string load costs 13 clocks
// - Single string port output costs 13 clocks
// - Repeat prefix loops string op; move 4+9n
// - Repeated port output costs 5+9n clocks
// - Repeated load costs 3+9n clocks
module lsd_decoder import lsd_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  output logic byte_ready_o,
  input wire logic [CNT_W-1:0] count_i,
  output logic dec_valid_o,
  output lsd_dec_t dec_o,
  output logic busy_o,
  output logic [CNT_W-1:0] count_o,
  output logic count_dec_o,
  output logic done_o
);

  // Elaboration check on the count width
  if (CNT_W < 1 || CNT_W > 32) begin : g_chk
    $error("lsd_decoder: CNT_W must be 1 to 32");
  end

  typedef struct packed {
    lsd_st_t st;
    logic rep;
    logic [7:0] opc;
    lsd_dec_t dec;
    logic [1:0] imm_left;
    logic iter;
    logic [7:0] cyc;
    logic [CNT_W-1:0] cnt;
    logic dvalid;
    logic [7:0] span;
  } lsd_state_t;

  lsd_state_t r, nxt;
  logic take;
  logic phase_end;
  logic [CNT_W-1:0] cnt_after;
  logic [1:0] modf;
  logic [2:0] regf;

  // Handshake and phase status
  assign byte_ready_o = (r.st != LSD_EXEC);
  assign take = byte_valid_i && byte_ready_o;
  assign phase_end = (r.st == LSD_EXEC) && (r.cyc == 8'h00_00);
  assign cnt_after = r.iter ? CNT_W'(r.cnt - 1'b1) : r.cnt;
  assign modf = byte_i[7:6];
  assign regf = byte_i[5:3];

  // Next-state logic for decode and execution timing
  always_comb begin
    nxt = r;
    nxt.dvalid = 1'b0;
    case (r.st)
      LSD_IDLE: begin
        if (take) begin
          nxt.opc = byte_i;
          nxt.dec = '0;
          nxt.dec.word = byte_i[0];
          nxt.dec.cost = LSD_CYC_REG;
          nxt.iter = 1'b0;
          if (byte_i == LSD_PREFIX_REP) begin
            nxt.rep = 1'b1;
          end else if ((byte_i & LSD_MASK_W) == LSD_OPC_GRP3 || (byte_i & LSD_MASK_DW) == LSD_OPC_XOR_RM ||
                       (byte_i & LSD_MASK_W) == LSD_OPC_TEST_RM) begin
            nxt.st = LSD_MODRM;
          end else if ((byte_i & LSD_MASK_W) == LSD_OPC_XOR_ACC) begin
            nxt.dec.op = LSD_OP_XOR_ACC;
            nxt.imm_left = byte_i[0] ? 2'h2 : 2'h1;
            nxt.st = LSD_IMM;
          end else if ((byte_i & LSD_MASK_W) == LSD_OPC_TEST_ACC) begin
            nxt.dec.op = LSD_OP_TEST_ACC;
            nxt.imm_left = byte_i[0] ? 2'h2 : 2'h1;
            nxt.st = LSD_IMM;
          end else begin
            // String ops and anything unknown go straight to execution
            nxt.dec.rep = r.rep;
            if ((byte_i & LSD_MASK_W) == LSD_OPC_LOAD) begin
              nxt.dec.op = string_load_op;
              nxt.dec.cost = r.rep ? LSD_CYC_REP_LOAD : LSD_CYC_STRING;
            end else if ((byte_i & LSD_MASK_W) == LSD_OPC_OUT) begin
              nxt.dec.op = string_port_output_op;
              nxt.dec.cost = r.rep ? LSD_CYC_REP_OUT : LSD_CYC_STRING;
            end else if ((byte_i & LSD_MASK_W) == LSD_OPC_MOVE) begin
              nxt.dec.op = string_move_op;
              nxt.dec.cost = r.rep ? LSD_CYC_REP_MOVE : LSD_CYC_STRING;
            end else begin
              nxt.dec.rep = 1'b0;
            end
            nxt.cnt = count_i;
            nxt.cyc = nxt.dec.cost - 8'h00_01;
            nxt.dvalid = 1'b1;
            nxt.rep = 1'b0;
            nxt.st = LSD_EXEC;
          end
        end
      end
      LSD_MODRM: begin
        if (take) begin
          nxt.dec.mem = (modf != LSD_MOD_REG);
          nxt.st = LSD_EXEC;
          if ((r.opc & LSD_MASK_W) == LSD_OPC_GRP3) begin
            if (regf == LSD_REG_INVERT) begin
              nxt.dec.op = LSD_OP_INVERT;
              nxt.dec.cost = nxt.dec.mem ? LSD_CYC_MEM : LSD_CYC_REG;
            end else if (regf == LSD_REG_TEST) begin
              nxt.dec.op = LSD_OP_TEST_IMM;
              nxt.dec.cost = nxt.dec.mem ? LSD_CYC_MEM_IMM : LSD_CYC_REG;
              nxt.imm_left = r.opc[0] ? 2'h2 : 2'h1;
              nxt.st = LSD_IMM;
            end
          end else if ((r.opc & LSD_MASK_DW) == LSD_OPC_XOR_RM) begin
            nxt.dec.op = LSD_OP_XOR_RM;
            nxt.dec.cost = nxt.dec.mem ? LSD_CYC_MEM : LSD_CYC_REG;
          end else begin
            nxt.dec.op = LSD_OP_TEST_RM;
            nxt.dec.cost = nxt.dec.mem ? LSD_CYC_MEM : LSD_CYC_REG;
          end
          if (nxt.st == LSD_EXEC) begin
            nxt.cyc = nxt.dec.cost - 8'h00_01;
            nxt.dvalid = 1'b1;
            nxt.rep = 1'b0;
          end
        end
      end
      LSD_IMM: begin
        if (take) begin
          nxt.imm_left = r.imm_left - 2'h1;
          if (r.imm_left == 2'h1) begin
            nxt.cyc = r.dec.cost - 8'h00_01;
            nxt.dvalid = 1'b1;
            nxt.rep = 1'b0;
            nxt.st = LSD_EXEC;
          end
        end
      end
      LSD_EXEC: begin
        if (r.cyc != 8'h00_00) begin
          nxt.cyc = r.cyc - 8'h00_01;
        end else begin
          // End of base phase or of one iteration
          nxt.cnt = cnt_after;
          if (r.dec.rep && cnt_after != '0) begin
            nxt.iter = 1'b1;
            nxt.cyc = LSD_CYC_ITER - 8'h00_01;
          end else begin
            nxt.iter = 1'b0;
            nxt.st = LSD_IDLE;
          end
        end
      end
      default: nxt.st = LSD_IDLE;
    endcase
    // Cycles since the decode pulse, saturating; only the length checks read it
    if (nxt.dvalid) begin
      nxt.span = 8'h00_00;
    end else if (r.st == LSD_EXEC && r.span != 8'h00_FF) begin
      nxt.span = r.span + 8'h00_01;
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  // Outputs
  assign dec_valid_o = r.dvalid;
  assign dec_o = r.dec;
  assign busy_o = (r.st == LSD_EXEC);
  assign count_o = r.cnt;
  assign count_dec_o = phase_end && r.iter;
  assign done_o = phase_end && !(r.dec.rep && cnt_after != '0);

  // Checks on decoded costs and iteration behaviour
  invert_cost_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dec_valid_o && dec_o.op == LSD_OP_INVERT |-> dec_o.cost == (dec_o.mem ? 8'h00_07 : 8'h00_01))
    else $error("invert cost wrong");
  xor_cost_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dec_valid_o && dec_o.op inside {LSD_OP_XOR_RM, LSD_OP_XOR_ACC} |->
    dec_o.cost == ((dec_o.mem && dec_o.op == LSD_OP_XOR_RM) ? 8'h00_07 : 8'h00_01))
    else $error("xor cost wrong");
  test_rm_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dec_valid_o && dec_o.op == LSD_OP_TEST_RM |-> dec_o.cost == (dec_o.mem ? 8'h00_07 : 8'h00_01))
    else $error("test rm cost wrong");
  test_imm_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dec_valid_o && dec_o.op == LSD_OP_TEST_IMM |-> dec_o.cost == (dec_o.mem ? 8'h00_08 : 8'h00_01))
    else $error("test immediate cost wrong");
  load_cost_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dec_valid_o && dec_o.op == string_load_op |-> dec_o.cost == (dec_o.rep ? 8'h00_03 : 8'h00_0D))
    else $error("load cost wrong");
  out_cost_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dec_valid_o && dec_o.op == string_port_output_op |-> dec_o.cost == (dec_o.rep ? 8'h00_05 : 8'h00_0D))
    else $error("port output cost wrong");
  single_len_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    done_o && !dec_o.rep && dec_o.cost == 8'h00_0D |-> r.span == 8'h00_0C ##1 !busy_o)
    else $error("single string length wrong");
  rep_move_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    count_dec_o && dec_o.op == string_move_op && dec_o.rep && r.span < 8'h00_15 |->
    r.span == 8'h00_0C && (done_o == (count_o == CNT_W'(1))))
    else $error("repeated move timing wrong");
  width_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dec_valid_o |-> dec_o.word == r.opc[0])
    else $error("width bit not followed");
  count_step_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    count_dec_o |=> count_o == CNT_W'($past(count_o) - 1'b1))
    else $error("count not decremented");
  zero_count_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dec_valid_o && dec_o.rep && count_o == '0 |-> !count_dec_o [*3] ##[0:2] done_o)
    else $error("zero count iterated");

endmodule

// file: dv/tb_top.sv
`timescale 1ns/100ps
module tb_top import lsd_pkg::*;;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic byte_valid_i = 1'b0;
  logic [7:0] byte_i = 8'h00;
  logic [15:0] count_i = 16'h0000;
  logic byte_ready_o, dec_valid_o, busy_o, count_dec_o, done_o;
  lsd_dec_t dec_o;
  logic [15:0] count_o;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h3548_c699;
  logic [63:0] bs;
  int nb;

  lsd_decoder #(.CNT_W(16)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .byte_valid_i(byte_valid_i),
    .byte_i(byte_i), .byte_ready_o(byte_ready_o), .count_i(count_i), .dec_valid_o(dec_valid_o),
    .dec_o(dec_o), .busy_o(busy_o), .count_o(count_o), .count_dec_o(count_dec_o), .done_o(done_o));

  // Core clock, 4 ns
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Expected base cost of one generated instruction
  function automatic int exp_cost(input int k, input logic mem, input logic str, input int nb);
    if (str) begin
      if (nb == 1) begin
        return 13;
      end
      return (k == 6) ? 3 : ((k == 7) ? 5 : 4);
    end
    if (mem) begin
      return (k == 4) ? 8 : 7;
    end
    return 1;
  endfunction

  task automatic push(input logic [7:0] b);
    bs[8*nb+:8] = b;
    nb++;
  endtask

  // Offer the queued bytes, then follow the execution cycle by cycle
  task automatic run(input lsd_op_t op, input logic w, ck_m, m, rp, input logic [15:0] cnt, input int cost);
    int n;
    int d;
    int dn;
    n = 0;
    d = 0;
    dn = 0;
    for (int i = 0; i < nb; i++) begin
      @(negedge mclk_i);
      byte_valid_i = 1'b1;
      byte_i = bs[8*i+:8];
      count_i = cnt;
    end
    @(negedge mclk_i);
    byte_valid_i = 1'b0;
    byte_i = 8'(xs());
    count_i = 16'(xs());
    chk(dec_valid_o, 1);
    chk(dec_o.op, op);
    if (op != LSD_OP_NONE) chk(dec_o.word, w);
    if (ck_m) chk(dec_o.mem, m);
    chk(dec_o.rep, rp);
    chk(dec_o.cost, cost);
    if (rp) chk(count_o, cnt);
    while (busy_o === 1'b1 && n < 100) begin
      n++;
      d += (count_dec_o === 1'b1);
      dn += (done_o === 1'b1);
      chk(byte_ready_o, 0);
      @(negedge mclk_i);
    end
    chk(n, rp ? cost + 9 * cnt : cost);
    chk(d, rp ? cnt : 0);
    chk(dn, 1);
    if (rp) chk(count_o, 0);
  endtask

  // Hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      conclude();
    end
  end

  // Reset, then hand-picked kinds first and random instructions after
  initial begin
    logic [31:0] r;
    int k, ni, cost;
    logic w, mdr, str;
    logic [1:0] md;
    logic [2:0] rg;
    logic [7:0] opc;
    lsd_op_t op;
    repeat (5) @(negedge mclk_i);
    chk(byte_ready_o, 1);
    chk(busy_o, 0);
    chk(dec_valid_o, 0);
    rst_n_i = 1'b1;
    for (int t = 0; t < 400; t++) begin
      r = xs();
      k = (t < 12) ? t : r % 12;
      w = r[8];
      md = r[10:9];
      rg = r[13:11];
      mdr = 1'b0;
      ni = 0;
      str = 1'b0;
      nb = 0;
      bs = '0;
      repeat (r[5:4] % 3) push(8'hF2);
      case (k)
        0: begin
          opc = {7'b1111011, w};
          mdr = 1'b1;
          rg = 3'h2;
          op = LSD_OP_INVERT;
        end
        1: begin
          opc = {6'b001100, r[14], w};
          mdr = 1'b1;
          op = LSD_OP_XOR_RM;
        end
        2: begin
          opc = {7'b0011010, w};
          ni = w + 1;
          op = LSD_OP_XOR_ACC;
        end
        3: begin
          opc = {7'b1000010, w};
          mdr = 1'b1;
          op = LSD_OP_TEST_RM;
        end
        4: begin
          opc = {7'b1111011, w};
          mdr = 1'b1;
          rg = 3'h0;
          ni = w + 1;
          op = LSD_OP_TEST_IMM;
        end
        5: begin
          opc = {7'b1010100, w};
          ni = w + 1;
          op = LSD_OP_TEST_ACC;
        end
        6: begin
          opc = {7'b1010110, w};
          str = 1'b1;
          op = string_load_op;
        end
        7: begin
          opc = {7'b0110111, w};
          str = 1'b1;
          op = string_port_output_op;
        end
        8: begin
          opc = {7'b1010010, w};
          str = 1'b1;
          op = string_move_op;
        end
        9: begin
          opc = {7'b1111011, w};
          mdr = 1'b1;
          rg = (rg == 3'h0 || rg == 3'h2) ? 3'h5 : rg;
          op = LSD_OP_NONE;
        end
        default: begin
          opc = 8'h90;
          op = LSD_OP_NONE;
        end
      endcase
      push(opc);
      if (mdr) push({md, rg, r[17:15]});
      repeat (ni) push(8'(xs()));
      cost = exp_cost(k, mdr && md != 2'h3 && op != LSD_OP_NONE, str, nb);
      run(op, w, mdr, md != 2'h3, str && nb > 1, {14'h0000, r[7:6]}, cost);
    end
    conclude();
  end
endmodule
